/* File: logic/flash_cfg_pkg.sv */
// Constants, register map and state type for the flash self-programming access block.
// Assumes an AXI4-Lite master with 32-bit data and one outstanding access per direction.
// Functional notes
// - Select bit steers access to config region
// - Config region sits at bit 15 set
// - Inaccessible config reads return zero word
// - User identification words readable and writable
// - Identification and configuration words are read-only
// - Read start completes, then data registers hold
// - Low data register holds word bits 7-0
// - High data register holds word bits 13-8
// - High data register bits 7-6 read zero
// - Data registers not cleared by reset
// - Latches return blank after write or erase
// - Erase acts on exactly one row
package flash_cfg_pkg;
  // Bus geometry
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_DATA_LOW = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_DATA_HIGH = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_ADDR_HIGH = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_CONTROL = 8'h10;
  // Control register field positions
  localparam int unsigned CTL_READ_BIT = 0;
  localparam int unsigned CTL_WRITE_BIT = 1;
  localparam int unsigned CTL_WREN_BIT = 2;
  localparam int unsigned CTL_ERASE_BIT = 4;
  localparam int unsigned CTL_LATCH_ONLY_BIT = 5;
  localparam int unsigned CTL_CFG_BIT = 6;
  // Word and address widths
  localparam int unsigned WORD_W = 14;
  localparam int unsigned HIGH_W = 6;
  localparam int unsigned ADDR_HIGH_W = 7;
  localparam int unsigned PC_W = 16;
  localparam int unsigned LATCH_COUNT = 32;
  localparam int unsigned LATCH_IDX_W = 5;
  localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3FFF;
  // Reset values
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RESET = 7'h00;
  localparam logic CTL_BIT_RESET = 1'b0;
  // Configuration space map
  localparam logic [PC_W-1:0] CFG_USER_FIRST = 16'h8000;
  localparam logic [PC_W-1:0] CFG_USER_LAST = 16'h8003;
  localparam logic [PC_W-1:0] CFG_DEV_ID = 16'h8005;
  localparam logic [PC_W-1:0] CFG_REV_ID = 16'h8006;
  localparam logic [PC_W-1:0] CFG_WORD1 = 16'h8007;
  localparam logic [PC_W-1:0] CFG_WORD2 = 16'h8008;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_READ_MEM,
    S_READ_CFG,
    S_ERASE,
    S_PROGRAM
  } seq_state_t;
endpackage

/* File: logic/flash_config_space_access.sv */
// Flash self-programming access: data, address and control registers on AXI4-Lite,
// word read, row erase, latch load and row program, and configuration space access.
// Assumes software runs the row edit and verify flows and polls the busy bits.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module flash_config_space_access #(
  parameter int unsigned MEM_AW = 10, // Program array address width
  parameter logic [13:0] DEVICE_ID = 14'h0123, // Arbitrary value
  parameter logic [13:0] REVISION_ID = 14'h0001, // Arbitrary value
  parameter logic [13:0] CONFIG_WORD1 = 14'h3FFF, // Plain default
  parameter logic [13:0] CONFIG_WORD2 = 14'h3FFF // Plain default
) (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [flash_cfg_pkg::AXI_AW-1:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [flash_cfg_pkg::AXI_DW-1:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic [flash_cfg_pkg::AXI_AW-1:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [flash_cfg_pkg::AXI_DW-1:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i // Read data ready
);
  import flash_cfg_pkg::*;

  // Elaboration check on array size
  if (MEM_AW <= LATCH_IDX_W || MEM_AW > PC_W - 1)
  begin : g_bad_aw
    $error("MEM_AW must exceed the latch index width and fit below bit 15");
  end

  localparam int unsigned ROW_W = MEM_AW - LATCH_IDX_W;

  // Bus write side state
  logic aw_held_q;
  logic w_held_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // Bus read side state
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rbyte_q;
  // Software visible registers
  logic [7:0] data_low_q;
  logic [HIGH_W-1:0] data_high_q;
  logic [7:0] addr_low_q;
  logic [ADDR_HIGH_W-1:0] addr_high_q;
  logic cfg_sel_q;
  logic latch_only_q;
  logic erase_q;
  logic wren_q;
  logic [WORD_W-1:0] user_id_q [4];
  // Sequencer
  seq_state_t state_q;
  seq_state_t state_d;
  logic [LATCH_IDX_W-1:0] cnt_q;
  logic [LATCH_IDX_W-1:0] cnt_d;
  logic mem_we;
  logic [WORD_W-1:0] mem_wdata;
  logic mem_re;
  logic [WORD_W-1:0] mem_rdata;
  logic latch_load;
  logic latch_clear;
  logic [WORD_W-1:0] latch_rdata;
  logic cap_en;
  logic [WORD_W-1:0] cap_word;
  logic user_we;
  logic erase_done;

  // Write channel handshakes and decode
  wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take = s_axi_wvalid_i && s_axi_wready_o;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_is_dl = awaddr_q == OFS_DATA_LOW;
  wire wr_is_dh = awaddr_q == OFS_DATA_HIGH;
  wire wr_is_al = awaddr_q == OFS_ADDR_LOW;
  wire wr_is_ah = awaddr_q == OFS_ADDR_HIGH;
  wire wr_is_ctl = awaddr_q == OFS_CONTROL;
  wire wr_mapped = wr_is_dl || wr_is_dh || wr_is_al || wr_is_ah || wr_is_ctl;
  wire wr_ok = wr_fire && wlane_q;
  wire idle = state_q == S_IDLE;
  wire ctl_wr = wr_ok && wr_is_ctl && idle;
  wire go_read = ctl_wr && wbyte_q[CTL_READ_BIT];
  wire go_write = ctl_wr && wbyte_q[CTL_WRITE_BIT] && wbyte_q[CTL_WREN_BIT];
  wire new_cfg = wbyte_q[CTL_CFG_BIT];
  wire new_erase = wbyte_q[CTL_ERASE_BIT];
  wire new_latch_only = wbyte_q[CTL_LATCH_ONLY_BIT];

  // Configuration space address with bit 15 set
  wire [PC_W-1:0] cfg_addr = {1'b1, addr_high_q, addr_low_q};
  wire in_user = (cfg_addr >= CFG_USER_FIRST) && (cfg_addr <= CFG_USER_LAST);
  wire [1:0] user_idx = addr_low_q[1:0];
  wire [WORD_W-1:0] cfg_word =
    in_user ? user_id_q[user_idx] :
    (cfg_addr == CFG_DEV_ID) ? DEVICE_ID :
    (cfg_addr == CFG_REV_ID) ? REVISION_ID :
    (cfg_addr == CFG_WORD1) ? CONFIG_WORD1 :
    (cfg_addr == CFG_WORD2) ? CONFIG_WORD2 :
    '0;

  // Program array addressing
  wire [MEM_AW-1:0] prog_addr = MEM_AW'({addr_high_q, addr_low_q});
  wire [ROW_W-1:0] row_addr = prog_addr[MEM_AW-1:LATCH_IDX_W];
  wire [MEM_AW-1:0] row_word_addr = {row_addr, cnt_q};
  wire [WORD_W-1:0] data_word = {data_high_q, data_low_q};
  wire last_word = cnt_q == LATCH_IDX_W'(LATCH_COUNT - 1);

  // Sequencer next state and strobes
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    mem_we = 1'b0;
    mem_wdata = BLANK_WORD;
    mem_re = 1'b0;
    latch_load = 1'b0;
    latch_clear = 1'b0;
    cap_en = 1'b0;
    cap_word = mem_rdata;
    user_we = 1'b0;
    erase_done = 1'b0;
    unique case (state_q)
      S_IDLE:
      begin
        cnt_d = '0;
        if (go_read)
        begin
          mem_re = !new_cfg;
          state_d = new_cfg ? S_READ_CFG : S_READ_MEM;
        end
        else if (go_write && new_cfg)
        begin
          // Only user words take a write; read-only words are left alone
          user_we = in_user && !new_latch_only;
          latch_clear = !new_latch_only;
        end
        else if (go_write && new_erase)
        begin
          state_d = S_ERASE;
        end
        else if (go_write)
        begin
          latch_load = 1'b1;
          state_d = new_latch_only ? S_IDLE : S_PROGRAM;
        end
      end
      S_READ_MEM:
      begin
        cap_en = 1'b1;
        cap_word = mem_rdata;
        state_d = S_IDLE;
      end
      S_READ_CFG:
      begin
        cap_en = 1'b1;
        cap_word = cfg_word;
        state_d = S_IDLE;
      end
      S_ERASE:
      begin
        mem_we = 1'b1;
        mem_wdata = BLANK_WORD;
        cnt_d = cnt_q + 1'b1;
        if (last_word)
        begin
          latch_clear = 1'b1;
          erase_done = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_PROGRAM:
      begin
        mem_we = 1'b1;
        mem_wdata = latch_rdata;
        cnt_d = cnt_q + 1'b1;
        if (last_word)
        begin
          latch_clear = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Data registers keep their contents through reset; capture beats a bus write
  always_ff @(posedge mclk_i)
  begin
    if (cap_en)
    begin
      data_low_q <= cap_word[7:0];
      data_high_q <= cap_word[WORD_W-1:8];
    end
    else
    begin
      if (wr_ok && wr_is_dl)
      begin
        data_low_q <= wbyte_q;
      end
      if (wr_ok && wr_is_dh)
      begin
        data_high_q <= wbyte_q[HIGH_W-1:0];
      end
    end
  end

  // User identification words are nonvolatile and ignore reset
  always_ff @(posedge mclk_i)
  begin
    if (user_we)
    begin
      user_id_q[user_idx] <= data_word;
    end
  end

  // Address and control registers; mode bits are written only while idle, erase_q also clears as the erase ends
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_low_q <= ADDR_LOW_RESET;
      addr_high_q <= ADDR_HIGH_RESET;
      cfg_sel_q <= CTL_BIT_RESET;
      latch_only_q <= CTL_BIT_RESET;
      erase_q <= CTL_BIT_RESET;
      wren_q <= CTL_BIT_RESET;
    end
    else
    begin
      if (wr_ok && wr_is_al && idle)
      begin
        addr_low_q <= wbyte_q;
      end
      if (wr_ok && wr_is_ah && idle)
      begin
        addr_high_q <= wbyte_q[ADDR_HIGH_W-1:0];
      end
      if (ctl_wr)
      begin
        cfg_sel_q <= new_cfg;
        latch_only_q <= new_latch_only;
        erase_q <= new_erase;
        wren_q <= wbyte_q[CTL_WREN_BIT];
      end
      else if (erase_done)
      begin
        erase_q <= 1'b0;
      end
    end
  end

  // Write channel: address and data taken in either order, response after both
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (w_take)
      begin
        w_held_q <= 1'b1;
        wbyte_q <= s_axi_wdata_i[7:0];
        wlane_q <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_i)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o = !w_held_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // Read decode; busy flags show in the start bit positions
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire rd_busy = (state_q == S_READ_MEM) || (state_q == S_READ_CFG);
  wire wr_busy = (state_q == S_ERASE) || (state_q == S_PROGRAM);
  wire [7:0] ctl_view = {1'b1, cfg_sel_q, latch_only_q, erase_q, 1'b0, wren_q, wr_busy,
    rd_busy};
  wire rd_is_dl = s_axi_araddr_i == OFS_DATA_LOW;
  wire rd_is_dh = s_axi_araddr_i == OFS_DATA_HIGH;
  wire rd_is_al = s_axi_araddr_i == OFS_ADDR_LOW;
  wire rd_is_ah = s_axi_araddr_i == OFS_ADDR_HIGH;
  wire rd_is_ctl = s_axi_araddr_i == OFS_CONTROL;
  wire rd_mapped = rd_is_dl || rd_is_dh || rd_is_al || rd_is_ah || rd_is_ctl;
  wire [7:0] rd_view =
    rd_is_dl ? data_low_q :
    rd_is_dh ? {2'b00, data_high_q} :
    rd_is_al ? addr_low_q :
    rd_is_ah ? {1'b1, addr_high_q} :
    rd_is_ctl ? ctl_view :
    8'h00;

  // Read channel: one access at a time
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rbyte_q <= '0;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rbyte_q <= rd_view;
    end
    else if (rvalid_q && s_axi_rready_i)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = {24'h00_0000, rbyte_q};

  // Program word array
  prog_word_mem #(
    .AW(MEM_AW),
    .DW(WORD_W)
  ) u_mem (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .we_i(mem_we),
    .waddr_i(row_word_addr),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(prog_addr),
    .rdata_o(mem_rdata)
  );

  // Row write latches
  write_latch_bank #(
    .N(LATCH_COUNT),
    .IW(LATCH_IDX_W),
    .DW(WORD_W),
    .BLANK(BLANK_WORD)
  ) u_latch (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(latch_load),
    .load_idx_i(addr_low_q[LATCH_IDX_W-1:0]),
    .load_data_i(data_word),
    .clear_i(latch_clear),
    .rd_idx_i(cnt_q),
    .rd_data_o(latch_rdata)
  );
endmodule

/* File: logic/prog_word_mem.sv */
// Program word array with one write port and one registered read port.
// Assumes the caller never needs read data before the edge after the read strobe.
`timescale 1ns/1ps
module prog_word_mem #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 14
) (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic we_i, // Write strobe
  input wire logic [AW-1:0] waddr_i, // Write address
  input wire logic [DW-1:0] wdata_i, // Write word
  input wire logic re_i, // Read strobe
  input wire logic [AW-1:0] raddr_i, // Read address
  output logic [DW-1:0] rdata_o // Registered read word
);
  logic [DW-1:0] mem_q [2**AW];

  // Array contents survive reset
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Read data register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= '0;
    end
    else if (re_i)
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

/* File: logic/write_latch_bank.sv */
// Bank of program write latches, loaded one at a time and blanked together.
// Assumes clear and load are never asked for in the same cycle.
`timescale 1ns/1ps
module write_latch_bank #(
  parameter int unsigned N = 32,
  parameter int unsigned IW = 5,
  parameter int unsigned DW = 14,
  parameter logic [DW-1:0] BLANK = 14'h3FFF
) (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic load_i, // Load one latch
  input wire logic [IW-1:0] load_idx_i, // Latch to load
  input wire logic [DW-1:0] load_data_i, // Word to load
  input wire logic clear_i, // Blank all latches
  input wire logic [IW-1:0] rd_idx_i, // Latch to read
  output logic [DW-1:0] rd_data_o // Selected latch word
);
  logic [DW-1:0] latch_q [N];

  // One latch per entry, blanked at reset or on completion
  for (genvar i = 0; i < N; i++)
  begin : g_latch
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        latch_q[i] <= BLANK;
      end
      else if (clear_i)
      begin
        latch_q[i] <= BLANK;
      end
      else if (load_i && (load_idx_i == IW'(i)))
      begin
        latch_q[i] <= load_data_i;
      end
    end
  end

  // Selected latch out
  assign rd_data_o = latch_q[rd_idx_i];
endmodule

/* File: verif/cpu_model.sv */
// Processor model running self-programming software over AXI4-Lite.
// Assumes the caller waits for reset release before the first task.
`timescale 1ns/1ps
module cpu_model (
  input wire logic mclk_i, // Clock
  output logic [7:0] aw_a_o, // AW addr
  output logic aw_v_o, // AW valid
  input wire logic aw_r_i, // AW ready
  output logic [31:0] w_d_o, // W data
  output logic [3:0] w_s_o, // W strobe
  output logic w_v_o, // W valid
  input wire logic w_r_i, // W ready
  input wire logic [1:0] b_rs_i, // B resp
  input wire logic b_v_i, // B valid
  output logic b_r_o, // B ready
  output logic [7:0] ar_a_o, // AR addr
  output logic ar_v_o, // AR valid
  input wire logic ar_r_i, // AR ready
  input wire logic [31:0] r_d_i, // R data
  input wire logic [1:0] r_rs_i, // R resp
  input wire logic r_v_i, // R valid
  output logic r_r_o // R ready
);
  import flash_cfg_pkg::*;
  logic [13:0] ram [32]; // RAM image of one row
  logic [1:0] last_b;
  logic [1:0] last_r;
  logic [3:0] strb = 4'h1; // Strobe for the next write
  // Idle bus at time zero
  initial
  begin
    {aw_a_o, aw_v_o, w_d_o, w_v_o, b_r_o, ar_a_o, ar_v_o, r_r_o} = '0;
    w_s_o = 4'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    aw_a_o <= a;
    aw_v_o <= 1'b1;
    w_d_o <= {24'h00_0000, d};
    w_s_o <= strb;
    w_v_o <= 1'b1;
    b_r_o <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (aw_r_i) aw_v_o <= 1'b0;
      if (w_r_i) w_v_o <= 1'b0;
    end
    while (!b_v_i);
    last_b = b_rs_i;
    b_r_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    ar_a_o <= a;
    ar_v_o <= 1'b1;
    r_r_o <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (ar_r_i) ar_v_o <= 1'b0;
    end
    while (!r_v_i);
    d = r_d_i;
    last_r = r_rs_i;
    r_r_o <= 1'b0;
  endtask
  task automatic set_addr(input logic [15:0] a);
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_ADDR_HIGH, {1'b0, a[14:8]});
  endtask
  // Start an operation and wait out both busy bits
  task automatic go(input logic [7:0] c);
    logic [31:0] v;
    wr(OFS_CONTROL, c);
    do rd(OFS_CONTROL, v);
    while (v[1:0] != 2'h0);
  endtask
  task automatic put_word(input logic [13:0] w);
    wr(OFS_DATA_LOW, w[7:0]);
    wr(OFS_DATA_HIGH, {2'h0, w[13:8]});
  endtask
  task automatic read_word(input logic [15:0] a, input logic cfg, output logic [13:0] w);
    logic [31:0] lo;
    logic [31:0] hi;
    set_addr(a);
    go(cfg ? 8'h41 : 8'h01);
    rd(OFS_DATA_LOW, lo);
    rd(OFS_DATA_HIGH, hi);
    w = {hi[5:0], lo[7:0]};
  endtask
  // Latch-only loads, the last load starts programming
  task automatic prog_row(input logic [15:0] row);
    for (int k = 0; k < 32; k++)
    begin
      set_addr(16'(row + k));
      put_word(ram[k]);
      go(k == 31 ? 8'h06 : 8'h26);
    end
  endtask
  // Read, edit, erase, rewrite, then verify the row
  task automatic edit_word(input logic [15:0] row, input int idx, input logic [13:0] w,
                           output int bad);
    logic [13:0] got;
    for (int k = 0; k < 32; k++) read_word(16'(row + k), 1'b0, ram[k]);
    ram[idx] = w;
    set_addr(row);
    go(8'h16);
    prog_row(row);
    bad = 0;
    for (int k = 0; k < 32; k++)
    begin
      read_word(16'(row + k), 1'b0, got);
      if (got !== ram[k]) bad++;
    end
  endtask
endmodule

/* File: verif/flash_access_chk.sv */
// Bus assertions for the flash access block.
// Bound to the top module; watches its ports only.
`timescale 1ns/1ps
module flash_access_chk (
  input wire logic mclk_i, // Clock
  input wire logic rst_b_i, // Reset
  input wire logic [flash_cfg_pkg::AXI_AW-1:0] s_axi_awaddr_i, // AW addr
  input wire logic s_axi_awvalid_i, // AW valid
  input wire logic s_axi_awready_o, // AW ready
  input wire logic s_axi_wready_o, // W ready
  input wire logic [1:0] s_axi_bresp_o, // B resp
  input wire logic s_axi_bvalid_o, // B valid
  input wire logic s_axi_bready_i, // B ready
  input wire logic [flash_cfg_pkg::AXI_AW-1:0] s_axi_araddr_i, // AR addr
  input wire logic s_axi_arvalid_i, // AR valid
  input wire logic s_axi_arready_o, // AR ready
  input wire logic [flash_cfg_pkg::AXI_DW-1:0] s_axi_rdata_o, // R data
  input wire logic [1:0] s_axi_rresp_o, // R resp
  input wire logic s_axi_rvalid_o, // R valid
  input wire logic s_axi_rready_i // R ready
);
  import flash_cfg_pkg::*;
  logic [7:0] ar_q;
  logic [7:0] aw_q;
  // Addresses taken at each handshake
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ar_q <= 8'h00;
      aw_q <= 8'h00;
    end
    else
    begin
      if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i;
      if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
    end
  end
  // Unmapped or unaligned decode
  wire ar_bad = (ar_q > OFS_CONTROL) || (ar_q[1:0] != 2'h0);
  wire aw_bad = (aw_q > OFS_CONTROL) || (aw_q[1:0] != 2'h0);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_b_clear: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("bvalid stayed after bready");
  a_r_clear: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("rvalid stayed after rready");
  a_w_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  a_r_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during response");
  a_rdy_back: assert property ($fell(s_axi_bvalid_o) |-> s_axi_awready_o && s_axi_wready_o)
    else $error("write readies not back");
  a_r_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_high_zero: assert property (s_axi_rvalid_o && ar_q == OFS_DATA_HIGH |->
    !s_axi_rdata_o[7:6])
    else $error("high data bits 7-6 not zero");
  a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  a_rd_resp: assert property (s_axi_rvalid_o |->
    s_axi_rresp_o == (ar_bad ? RESP_SLVERR : RESP_OKAY))
    else $error("read response wrong");
  a_wr_resp: assert property ($rose(s_axi_bvalid_o) |->
    s_axi_bresp_o == (aw_bad ? RESP_SLVERR : RESP_OKAY))
    else $error("write response wrong");
  c_wr_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
  c_rd_high: cover property (s_axi_rvalid_o && ar_q == OFS_DATA_HIGH);
  c_rd_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
endmodule

/* File: verif/flash_config_space_access_tb.sv */
// Testbench for the flash access block: register, config space and row flows.
// Drives the block through the processor model; bound checker watches the bus.
`timescale 1ns/1ps
module flash_config_space_access_tb;
  import flash_cfg_pkg::*;
  localparam logic [13:0] DEV_ID = 14'h2B4C; // Arbitrary value
  localparam logic [13:0] REV_ID = 14'h0A07; // Arbitrary value
  localparam logic [13:0] CW1 = 14'h1555;
  localparam logic [13:0] CW2 = 14'h2AAA;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  wire [7:0] aw_a, ar_a;
  wire [31:0] w_d, r_d;
  wire [3:0] w_s;
  wire [1:0] b_rs, r_rs;
  wire aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  int err_total = 0;
  int n_checks = 0;
  always #20 mclk_i = ~mclk_i;
  flash_config_space_access #(.MEM_AW(10), .DEVICE_ID(DEV_ID), .REVISION_ID(REV_ID),
    .CONFIG_WORD1(CW1), .CONFIG_WORD2(CW2)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r),
    .s_axi_bresp_o(b_rs), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_rs), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r));
  cpu_model u_cpu (.mclk_i(mclk_i), .aw_a_o(aw_a), .aw_v_o(aw_v), .aw_r_i(aw_r),
    .w_d_o(w_d), .w_s_o(w_s), .w_v_o(w_v), .w_r_i(w_r), .b_rs_i(b_rs), .b_v_i(b_v),
    .b_r_o(b_r), .ar_a_o(ar_a), .ar_v_o(ar_v), .ar_r_i(ar_r), .r_d_i(r_d), .r_rs_i(r_rs),
    .r_v_i(r_v), .r_r_o(r_r));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #1_200_000;
    err_total++;
    final_report();
  end
  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [13:0] w;
    logic [13:0] exp [10];
    int bad;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    u_cpu.wr(OFS_DATA_LOW, 8'hA5);
    u_cpu.wr(OFS_DATA_HIGH, 8'hFF);
    u_cpu.rd(OFS_DATA_LOW, v);
    check(v, 32'h0000_00A5);
    u_cpu.rd(OFS_DATA_HIGH, v);
    check(v, 32'h0000_003F);
    u_cpu.wr(OFS_ADDR_LOW, 8'h5A);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    u_cpu.rd(OFS_DATA_LOW, v);
    check(v, 32'h0000_00A5);
    u_cpu.rd(OFS_DATA_HIGH, v);
    check(v, 32'h0000_003F);
    u_cpu.rd(OFS_ADDR_LOW, v);
    check(v, 32'h0000_0000);
    // A write with its low strobe clear stores nothing but still answers OKAY
    u_cpu.strb = 4'h0;
    u_cpu.wr(OFS_DATA_LOW, 8'h3C);
    u_cpu.strb = 4'h1;
    check(32'(u_cpu.last_b), 32'(RESP_OKAY));
    u_cpu.rd(OFS_DATA_LOW, v);
    check(v, 32'h0000_00A5);
    u_cpu.wr(8'h14, 8'h01);
    check(32'(u_cpu.last_b), 32'(RESP_SLVERR));
    u_cpu.rd(8'h14, v);
    check(v, 32'h0000_0000);
    $display("test registers done");
    // User IDs writable, identification and config words fixed
    for (int i = 0; i < 4; i++)
    begin
      u_cpu.put_word(14'(14'h1230 + i));
      u_cpu.set_addr(16'(16'h8000 + i));
      u_cpu.go(8'h46);
    end
    u_cpu.put_word(14'h0000);
    u_cpu.set_addr(16'h8005);
    u_cpu.go(8'h46);
    u_cpu.set_addr(16'h8007);
    u_cpu.go(8'h46);
    exp = '{14'h1230, 14'h1231, 14'h1232, 14'h1233, 14'h0000, DEV_ID, REV_ID, CW1, CW2,
      14'h0000};
    for (int i = 0; i < 10; i++)
    begin
      u_cpu.read_word(16'(16'h8000 + i), 1'b1, w);
      check(32'(w), 32'(exp[i]));
    end
    $display("test config space done");
    // Two rows programmed, one word of the first edited
    for (int k = 0; k < 32; k++) u_cpu.ram[k] = 14'(14'h0100 + k);
    u_cpu.prog_row(16'h0000);
    for (int k = 0; k < 32; k++) u_cpu.ram[k] = 14'(14'h0200 + k);
    u_cpu.prog_row(16'h0020);
    u_cpu.edit_word(16'h0000, 5, 14'h3ABC, bad);
    check(32'(bad), 32'h0000_0000);
    for (int k = 0; k < 64; k++)
    begin
      u_cpu.read_word(16'(k), 1'b0, w);
      check(32'(w), k == 5 ? 32'h0000_3ABC : 32'(k < 32 ? 14'h0100 + k : 14'h01E0 + k));
    end
    // A loaded latch is blanked by the erase that follows
    u_cpu.set_addr(16'h0043);
    u_cpu.put_word(14'h1111);
    u_cpu.go(8'h26);
    u_cpu.set_addr(16'h0040);
    u_cpu.go(8'h16);
    u_cpu.set_addr(16'h0045);
    u_cpu.put_word(14'h2222);
    u_cpu.go(8'h06);
    u_cpu.read_word(16'h0043, 1'b0, w);
    check(32'(w), 32'h0000_3FFF);
    u_cpu.read_word(16'h0045, 1'b0, w);
    check(32'(w), 32'h0000_2222);
    $display("test row flows done");
    final_report();
  end
endmodule
bind flash_config_space_access flash_access_chk u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));
